// ### arc_channel.sv
`timescale 1ns/10ps
// One converter channel sequencer: counts samples per output word
module arc_channel (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Control
  input  wire logic        sampleEn,
  input  wire logic        softReset,
  input  wire logic        powerDown,
  input  wire logic [2:0]  osrSel,
  // Status
  output logic             active,
  output logic             dataStrobe
);
  logic [11:0] cnt_r;
  logic [11:0] lastCnt;
  logic        hold;
  assign lastCnt = 12'((13'h1 << (arc_pkg::OSR_BASE_LOG2 + int'(osrSel))) - 13'h1);
  assign hold    = softReset | powerDown;
  assign active  = ~hold;
  always_ff @(posedge mclk) begin
    if (sys_rst || hold) begin
      cnt_r      <= 12'h000;
      dataStrobe <= 1'b0;
    end else begin
      dataStrobe <= 1'b0;
      if (sampleEn) begin
        if (cnt_r >= lastCnt) begin
          cnt_r      <= 12'h000;
          dataStrobe <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 12'h001;
        end
      end
    end
  end
endmodule : arc_channel

// ### arc_clk_div.sv
`timescale 1ns/10ps
// Prescaler: one-cycle enable every 2**divLog2 clocks
module arc_clk_div (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic [1:0] divLog2,
  // Enable out
  output logic            tick
);
  logic [2:0] cnt_r;
  logic [2:0] cntMask;
  assign cntMask = 3'((4'h1 << divLog2) - 4'h1);
  assign tick    = ((cnt_r & cntMask) == 3'h0);
  always_ff @(posedge mclk) begin
    if (sys_rst) cnt_r <= 3'h0;
    else         cnt_r <= cnt_r + 3'h1;
  end
endmodule : arc_clk_div

// ### arc_config.sv
`timescale 1ns/10ps
// Functional notes
// - OVERSAMPLING_RATIO_SEL field bits 15:13 picks ratio 32 to 4096 for all channels
// - OVERSAMPLING_RATIO_SEL field resets to code 011, ratio 256
// - Unimplemented bits read back as zero in both words
// - Bits 7:0 of first word hold a read/write reference trim
// - Second word is 24-bit read/write at address 0x0F
// - Bits 18:16 hold channels in soft reset, cleared at power-on
// - Bits 10:8 power channels down, cleared at power-on
// - Bit 7 set selects external reference, internal off; reset zero
// - Bit 6 set selects external clock, crystal off; reset one
// - Sampling clock is master clock divided by 1, 2, 4 or 8
module arc_config #(
  parameter int NUM_CH = 3
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // Register port
  input  wire logic              regWrEn,
  input  wire logic [4:0]        regAddr,
  input  wire logic [23:0]       regWrData,
  output logic [23:0]            regRdData,
  // Analog controls
  output logic [2:0]             oversampling_ratio_sel,
  output logic [7:0]             ref_tempco_trim,
  output logic                   ext_ref_select,
  output logic                   ext_clock_select,
  output logic                   intRefEnable,
  output logic                   crystalOscEnable,
  output logic                   analog_sampling_clock,
  // Channel state
  output logic [NUM_CH-1:0]      chanActive,
  output logic [NUM_CH-1:0]      chanDataStrobe
);
  logic [23:0]       adc_setup_reg_r;
  logic [23:0]       power_clock_setup_reg_r;
  logic              selAdc;
  logic              selPwr;
  logic [2:0]        osrField;
  logic [1:0]        preField;
  logic [NUM_CH-1:0] rstField;
  logic [NUM_CH-1:0] pdField;
  logic              sampleTick;
  logic [NUM_CH-1:0] chActNxt;
  logic [NUM_CH-1:0] chStbNxt;
  logic [23:0]       rdMux;

  assign selAdc = (regAddr == arc_pkg::ADC_SETUP_ADDR);
  assign selPwr = (regAddr == arc_pkg::PWR_CLK_ADDR);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      adc_setup_reg_r <= {6'h00, arc_pkg::PRESCALE_RESET, arc_pkg::OSR_RESET, 5'h00, arc_pkg::TRIM_RESET};
      power_clock_setup_reg_r <= arc_pkg::PWR_CLK_RESET;
    end else if (regWrEn) begin
      if (selAdc) adc_setup_reg_r <= regWrData & arc_pkg::ADC_SETUP_MASK;
      if (selPwr) power_clock_setup_reg_r <= regWrData & arc_pkg::PWR_CLK_MASK;
    end
  end

  assign osrField = adc_setup_reg_r[arc_pkg::OSR_LSB +: 3];
  assign preField = adc_setup_reg_r[arc_pkg::PRESCALE_LSB +: 2];
  assign rstField = power_clock_setup_reg_r[arc_pkg::SOFT_RST_LSB +: NUM_CH];
  assign pdField  = power_clock_setup_reg_r[arc_pkg::PWR_DOWN_LSB +: NUM_CH];

  assign rdMux = selAdc ? adc_setup_reg_r :
                 selPwr ? power_clock_setup_reg_r : 24'h000000;

  // Prescaled sampling enable
  arc_clk_div uDiv (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .divLog2 (preField),
    .tick    (sampleTick)
  );

  // Channels see only registered fields, so updates apply after the write
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCh
      arc_channel uCh (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .sampleEn   (sampleTick),
        .softReset  (rstField[g]),
        .powerDown  (pdField[g]),
        .osrSel     (osrField),
        .active     (chActNxt[g]),
        .dataStrobe (chStbNxt[g])
      );
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdData              <= 24'h000000;
      oversampling_ratio_sel <= arc_pkg::OSR_RESET;
      ref_tempco_trim        <= arc_pkg::TRIM_RESET;
      ext_ref_select         <= 1'b0;
      ext_clock_select       <= 1'b1;
      intRefEnable           <= 1'b1;
      crystalOscEnable       <= 1'b0;
      analog_sampling_clock  <= 1'b0;
      chanActive             <= '0;
      chanDataStrobe         <= '0;
    end else begin
      regRdData              <= rdMux;
      oversampling_ratio_sel <= osrField;
      ref_tempco_trim        <= adc_setup_reg_r[arc_pkg::TRIM_LSB +: 8];
      ext_ref_select         <= power_clock_setup_reg_r[arc_pkg::EXT_REF_BIT];
      intRefEnable           <= ~power_clock_setup_reg_r[arc_pkg::EXT_REF_BIT];
      ext_clock_select       <= power_clock_setup_reg_r[arc_pkg::EXT_CLK_BIT];
      crystalOscEnable       <= ~power_clock_setup_reg_r[arc_pkg::EXT_CLK_BIT];
      analog_sampling_clock  <= sampleTick;
      chanActive             <= chActNxt;
      chanDataStrobe         <= chStbNxt;
    end
  end
endmodule : arc_config

// ### arc_config_sva.sv
`timescale 1ns/10ps
module arc_config_chk #(
  parameter int NUM_CH = 3
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              sys_rst,
  // Register port
  input wire logic              regWrEn,
  input wire logic [4:0]        regAddr,
  input wire logic [23:0]       regWrData,
  input wire logic [23:0]       regRdData,
  // Analog controls
  input wire logic [2:0]        oversampling_ratio_sel,
  input wire logic [7:0]        ref_tempco_trim,
  input wire logic              ext_ref_select,
  input wire logic              intRefEnable,
  input wire logic              ext_clock_select,
  input wire logic              crystalOscEnable,
  // Channel state
  input wire logic [NUM_CH-1:0] chanActive
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_cfg1_zero: assert property ($past(regAddr) == 5'h0F |-> (regRdData & ~24'h0707C0) == 24'h0)
    else $error("0x0F reserved bits set");
  a_cfg0_zero: assert property ($past(regAddr) == 5'h0D |-> (regRdData & ~24'h03E0FF) == 24'h0)
    else $error("0x0D reserved bits set");
  a_unmapped_zero: assert property (!($past(regAddr) inside {5'h0D, 5'h0F}) |-> regRdData == 24'h0)
    else $error("unmapped read nonzero");
  a_cfg1_readback: assert property (
    regWrEn && regAddr == 5'h0F ##1 regAddr == 5'h0F && !regWrEn |=> regRdData == ($past(regWrData, 2) & 24'h0707C0))
    else $error("0x0F readback wrong");
  a_osr_trim_out: assert property (
    regWrEn && regAddr == 5'h0D ##1 (!regWrEn) [*2] |=>
    {oversampling_ratio_sel, ref_tempco_trim} == {$past(regWrData, 3) >> 13, $past(regWrData, 3)} >> 0 ||
    (oversampling_ratio_sel == $past(regWrData[15:13], 3) && ref_tempco_trim == $past(regWrData[7:0], 3)))
    else $error("OVERSAMPLING_RATIO_SEL or trim output wrong");
  a_chan_active: assert property (regWrEn && regAddr == 5'h0F |=> ##1 chanActive == ~($past(regWrData[18:16], 2) | $past(regWrData[10:8], 2)))
    else $error("channel active wrong");
  a_ref_inverse: assert property (intRefEnable == !ext_ref_select) else $error("reference enable wrong");
  a_osc_inverse: assert property (crystalOscEnable == !ext_clock_select) else $error("crystal enable wrong");
endmodule : arc_config_chk
bind arc_config arc_config_chk #(.NUM_CH(NUM_CH)) arc_config_chk_inst (
  .mclk                   (mclk),
  .sys_rst                (sys_rst),
  .regWrEn                (regWrEn),
  .regAddr                (regAddr),
  .regWrData              (regWrData),
  .regRdData              (regRdData),
  .oversampling_ratio_sel (oversampling_ratio_sel),
  .ref_tempco_trim        (ref_tempco_trim),
  .ext_ref_select         (ext_ref_select),
  .intRefEnable           (intRefEnable),
  .ext_clock_select       (ext_clock_select),
  .crystalOscEnable       (crystalOscEnable),
  .chanActive             (chanActive)
);

// ### arc_config_tb.sv
`timescale 1ns/10ps
module arc_config_tb;
  logic mclk = 0, sys_rst = 1, regWrEn = 0;
  logic [4:0] regAddr = 5'h00;
  logic [23:0] regWrData = 24'h0, regRdData;
  logic [2:0] oversampling_ratio_sel, chanActive, chanDataStrobe;
  logic [7:0] ref_tempco_trim;
  logic ext_ref_select, ext_clock_select, intRefEnable, crystalOscEnable, analog_sampling_clock;
  int n_mismatch = 0, tests_run = 0;
  arc_config arc_config_inst (.*);
  initial forever #5 mclk = ~mclk;
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge mclk) #1;
    regWrEn = 1;
    regAddr = a;
    regWrData = d;
    @(posedge mclk) #1;
    regWrEn = 0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [23:0] e);
    regAddr = a;
    repeat (3) @(posedge mclk);
    #1 chk(regRdData, e);
  endtask : rd
  // Second gap between channel 0 strobes, once the new setting has settled
  task automatic period(input int exp);
    int n;
    for (int i = 0; i < 3; i++) begin
      n = 0;
      do begin
        @(posedge mclk) #1;
        n++;
      end while (chanDataStrobe[0] !== 1'b1 && n < 9999);
      if (n == 9999) begin
        n_mismatch++;
        summarize();
      end
    end
    chk(n, exp);
  endtask : period
  initial begin
    repeat (8) @(posedge mclk);
    #1 sys_rst = 0;
    rd(5'h0D, 24'h006050);
    chk({23'h000000, analog_sampling_clock}, 24'h000001);
    rd(5'h0F, 24'h000040);
    chk({ext_ref_select, ext_clock_select, intRefEnable, crystalOscEnable, chanActive}, 7'h37);
    wr(5'h0F, 24'hFFFFFF);
    rd(5'h0F, 24'h0707C0);
    chk({ext_ref_select, ext_clock_select, intRefEnable, crystalOscEnable, chanActive}, 7'h60);
    wr(5'h0D, 24'hFFFFFF);
    rd(5'h0D, 24'h03E0FF);
    wr(5'h0E, 24'hFFFFFF);
    rd(5'h0E, 24'h000000);
    wr(5'h0F, 24'h000000);
    for (int k = 0; k < 8; k++) begin
      wr(5'h0D, {6'h00, 2'(3 - k % 4), 3'(k), 13'h0000});
      period((32 << k) << (3 - k % 4));
    end
    summarize();
  end
endmodule : arc_config_tb

// ### arc_pkg.sv
package arc_pkg;
  // Register addresses
  localparam logic [4:0] ADC_SETUP_ADDR   = 5'h0D;
  localparam logic [4:0] PWR_CLK_ADDR     = 5'h0F;
  // adc_setup_reg fields
  localparam int OSR_LSB       = 13;
  localparam int PRESCALE_LSB  = 16;
  localparam int TRIM_LSB      = 0;
  // power_clock_setup_reg fields
  localparam int SOFT_RST_LSB  = 16;
  localparam int PWR_DOWN_LSB  = 8;
  localparam int EXT_REF_BIT   = 7;
  localparam int EXT_CLK_BIT   = 6;
  // Writable masks
  localparam logic [23:0] ADC_SETUP_MASK  = 24'h03E0FF;
  localparam logic [23:0] PWR_CLK_MASK    = 24'h0707C0;
  // Reset values
  localparam logic [2:0]  OSR_RESET       = 3'h3;
  localparam logic [1:0]  PRESCALE_RESET  = 2'h0;
  localparam logic [7:0]  TRIM_RESET      = 8'h50;
  localparam logic [23:0] PWR_CLK_RESET   = 24'h000040;
  // Smallest oversampling ratio, as a power of two
  localparam int OSR_BASE_LOG2 = 5;
  // Clock rate
  localparam int MCLK_HZ = 100000000;
endpackage : arc_pkg
